// [hw/eth_port_regs.svh]
// register offsets, field positions, reset values and counts of the ethernet port block
`ifndef ETH_PORT_REGS_SVH
`define ETH_PORT_REGS_SVH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define MAC_CONTROL_REG_OFS 8'h00
`define GLOBAL_CONTROL_REG_OFS 8'h04
`define MAC_FLOW_CONTROL_REG_OFS 8'h08
`define MAX_FRAME_SIZE_HIGH_OFS 8'h0c
`define MAX_FRAME_SIZE_LOW_OFS 8'h10
`define TX_RETRY_CONTROL_OFS 8'h14
`define RX_REJECT_CONTROL_OFS 8'h18
`define TX_FRAME_STATUS_LOW_OFS 8'h1c
`define TX_FRAME_STATUS_HIGH_OFS 8'h20
`define RX_FRAME_STATUS_BYTES_OFS 8'h24
`define PORT_STATUS_OFS 8'h28
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define MCR_TX_ENABLE 0
`define MCR_RX_ENABLE 1
`define MCR_FULL_DUPLEX 2
`define GCR_AUTO_FLOW 0
`define GCR_JAM_ENABLE 1
`define FCR_PAUSE_SEND 0
`define TRC_DEFER_RESEND 8
`define TRC_HEARTBEAT_RESEND 9
`define TRC_NO_CARRIER_FLUSH 10
`define TFS_NO_CARRIER 1
`define RFS3_CONTROL 4
`define RFS3_UNSUPPORTED 5
// ----------------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------------
`define GCR_RESET 2'h1
`define RFRC_RESET 6'h3f
`define MAX_FRAME_RESET 11'h7e0
`define MAX_FRAME_LIMIT 11'h7e0
`define JAM_BYTES 4
`define RUNT_BYTES 11'h040
`define HDR_BYTES 11'h012
`define PAUSE_TYPE 16'h8808
`define PAUSE_OPCODE 16'h0001
`define CRC_POLY 32'hedb88320
`define CRC_RESIDUE 32'hdebb20e3
`define CLK_HZ 10000000
`define RMII_REF_HZ 50000000
`define MII_REF_HZ 25000000
`define DCE_FAST_HZ 25000000
`define DCE_SLOW_HZ 2500000
`endif

// [hw/eth_port_pkg.sv]
// types shared by the ethernet port block
package eth_port_pkg;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_PRE = 3'b010,
    RX_DATA = 3'b100
  } rx_state_t;
  typedef enum logic [1:0] {
    JAM_OFF = 2'b01,
    JAM_ON = 2'b10
  } jam_state_t;
endpackage : eth_port_pkg

// [hw/ethernet_port_flow_and_frame_ctrl.sv]
// ethernet port: mii/rmii receive, jam and pause flow control, frame status and rejection
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "eth_port_regs.svh"
// Behaviour
// - jam first 4 bytes while queue high
// - frame in progress at crossing not jammed
// - keep jamming until queue falls below threshold
// - pause request bit sends pause, jam bit jams
// - control frames flag control, non-pause opcodes flag unsupported
// - reduced-pin mode: 8 signals, 50MHz reference
// - full mode: 12 signals, 25MHz reference
// - interface width follows select pin
// - dce full mode derives both port clocks
// - max frame size programmable up to 2047, reset 2016
// - length counts address through crc only
// - reject frames over the maximum size
// - status registers hold most recent frame
// - transmit status bits per transmit error
// - optional retransmit per error enable
// - no carrier with flush bit flushes queue
// - per-error receive rejection, reject by default
// - runts and collided frames always rejected
// - hostless: reject rx errors, retry tx errors
// - auto full duplex: pause per frame
// - overflow latches and blocks new frames
module ethernet_port_flow_and_frame_ctrl #(
  parameter int FAST_HALF_PERIOD = 1,
  parameter int SLOW_HALF_PERIOD = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite register slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // strap pins
  input wire logic hostlessModePin,
  input wire logic autoFlowPin,
  input wire logic duplexSelectPin,
  input wire logic interfaceWidthSelectPin,
  input wire logic portRoleSelectPin,
  // port pins
  input wire logic portReceiveClock,
  input wire logic portTransmitClock,
  input wire logic rxDv,
  input wire logic rxEr,
  input wire logic [3:0] rxd,
  input wire logic col,
  output logic portReceiveClockOut,
  output logic portTransmitClockOut,
  output logic portClockOe,
  output logic txJamEn,
  output logic [3:0] txd,
  // receive queue and packet processor
  input wire logic queueAboveHigh,
  input wire logic queueOverflow,
  input wire logic ppFrameDone,
  input wire logic [10:0] ppFrameLen,
  output logic ppFrameReject,
  output logic rxFrameAccept,
  output logic rxFrameReject,
  // transmit engine
  input wire logic txFrameDone,
  input wire logic [9:0] txErrors,
  output logic txRetry,
  output logic txQueueFlush,
  output logic pauseSend
);
  initial
  begin
    if (FAST_HALF_PERIOD < 1 || SLOW_HALF_PERIOD < FAST_HALF_PERIOD || SLOW_HALF_PERIOD > 255)
      $error("clock divider parameters out of range");
  end

  // ----------------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------------
  logic [11:0] syncA;
  logic [11:0] syncB;
  logic rxClkLast;
  logic txClkLast;
  // every pin passes two flops; only the second stage is read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA <= 12'h000;
      syncB <= 12'h000;
      rxClkLast <= 1'b0;
      txClkLast <= 1'b0;
    end
    else
    begin
      syncA <= {hostlessModePin, autoFlowPin, duplexSelectPin, interfaceWidthSelectPin, portRoleSelectPin,
                portReceiveClock, portTransmitClock, rxDv, rxEr, col, rxd[1:0]};
      syncB <= syncA;
      rxClkLast <= syncB[6];
      txClkLast <= syncB[5];
    end
  end
  logic [3:0] rxdA;
  logic [3:0] rxdB;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxdA <= 4'h0;
      rxdB <= 4'h0;
    end
    else
    begin
      rxdA <= rxd;
      rxdB <= rxdA;
    end
  end
  wire hostless_mode_pin = syncB[11];
  wire rmiiMode = syncB[8]; // reduced pins when high
  wire dceMode = syncB[7];

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  logic [2:0] macControl;
  logic [1:0] globalControl;
  logic pauseReq;
  logic [10:0] maxFrame;
  logic [10:0] txRetryCtrl;
  logic [5:0] rxRejectCtrl;
  logic [9:0] txStatus;
  logic [31:0] rxStatus;
  logic overflowLatch;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic haveAw;
  logic haveW;
  wire doWrite = haveAw && haveW && !bvalid;
  wire fullDuplex = hostless_mode_pin ? syncB[9] : macControl[`MCR_FULL_DUPLEX];
  wire autoFlow = hostless_mode_pin ? syncB[10] : globalControl[`GCR_AUTO_FLOW];
  wire macOn = hostless_mode_pin || (macControl[`MCR_TX_ENABLE] && macControl[`MCR_RX_ENABLE]);

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] st);
    for (int i = 0; i < 4; i++)
      if (st[i])
        old[i*8 +: 8] = nv[i*8 +: 8];
    return old;
  endfunction : merge

  // address phase and data phase are captured independently
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      wrAddr <= 8'h00;
      wrData <= 32'h0;
      wrStrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        wrAddr <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (doWrite)
      begin
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b1;
        bresp <= (wrAddr > `PORT_STATUS_OFS || wrAddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end
  // readies are flops so every output leaves a register; the held flags follow them
  assign haveAw = !awready;
  assign haveW = !wready;

  logic pauseTaken;
  // software-written control registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      macControl <= 3'h0;
      globalControl <= `GCR_RESET;
      pauseReq <= 1'b0;
      maxFrame <= `MAX_FRAME_RESET;
      txRetryCtrl <= 11'h000;
      rxRejectCtrl <= `RFRC_RESET;
    end
    else
    begin
      if (pauseTaken)
        pauseReq <= 1'b0;
      if (doWrite)
      begin
        if (wrAddr == `MAC_CONTROL_REG_OFS)
          macControl <= 3'(merge(32'(macControl), wrData, wrStrb));
        else if (wrAddr == `GLOBAL_CONTROL_REG_OFS)
          globalControl <= 2'(merge(32'(globalControl), wrData, wrStrb));
        else if (wrAddr == `MAC_FLOW_CONTROL_REG_OFS && wrStrb[0] && wrData[`FCR_PAUSE_SEND])
          pauseReq <= 1'b1;
        else if (wrAddr == `MAX_FRAME_SIZE_HIGH_OFS && wrStrb[0])
          maxFrame[10:8] <= wrData[2:0];
        else if (wrAddr == `MAX_FRAME_SIZE_LOW_OFS && wrStrb[0])
          maxFrame[7:0] <= wrData[7:0];
        else if (wrAddr == `TX_RETRY_CONTROL_OFS)
          txRetryCtrl <= 11'(merge(32'(txRetryCtrl), wrData, wrStrb));
        else if (wrAddr == `RX_REJECT_CONTROL_OFS)
          rxRejectCtrl <= 6'(merge(32'(rxRejectCtrl), wrData, wrStrb));
      end
    end
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
      rdata <= 32'h0;
      rresp <= 2'b00;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      arready <= 1'b0;
      rresp <= 2'b00;
      if (araddr == `MAC_CONTROL_REG_OFS)
        rdata <= 32'(macControl);
      else if (araddr == `GLOBAL_CONTROL_REG_OFS)
        rdata <= 32'(globalControl);
      else if (araddr == `MAC_FLOW_CONTROL_REG_OFS)
        rdata <= 32'(pauseReq);
      else if (araddr == `MAX_FRAME_SIZE_HIGH_OFS)
        rdata <= 32'(maxFrame[10:8]);
      else if (araddr == `MAX_FRAME_SIZE_LOW_OFS)
        rdata <= 32'(maxFrame[7:0]);
      else if (araddr == `TX_RETRY_CONTROL_OFS)
        rdata <= 32'(txRetryCtrl);
      else if (araddr == `RX_REJECT_CONTROL_OFS)
        rdata <= 32'(rxRejectCtrl);
      else if (araddr == `TX_FRAME_STATUS_LOW_OFS)
        rdata <= 32'(txStatus[7:0]);
      else if (araddr == `TX_FRAME_STATUS_HIGH_OFS)
        rdata <= 32'(txStatus[9:8]);
      else if (araddr == `RX_FRAME_STATUS_BYTES_OFS)
        rdata <= rxStatus;
      else if (araddr == `PORT_STATUS_OFS)
        rdata <= {26'h0, dceMode, rmiiMode, fullDuplex, hostless_mode_pin, queueAboveHigh, overflowLatch};
      else
      begin
        rdata <= 32'h0;
        rresp <= 2'b10;
      end
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // port clocks
  // ----------------------------------------------------------------------------
  logic [7:0] divCount;
  wire [7:0] halfPeriod = fullDuplex ? 8'(FAST_HALF_PERIOD) : 8'(SLOW_HALF_PERIOD);
  // dce drives both clocks from one divider; the fast/slow ratio stands for 25MHz/2.5MHz
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCount <= 8'h00;
      portReceiveClockOut <= 1'b0;
      portTransmitClockOut <= 1'b0;
      portClockOe <= 1'b0;
    end
    else
    begin
      portClockOe <= dceMode; // dte leaves the clocks to the phy
      if (divCount + 8'h01 >= halfPeriod)
      begin
        divCount <= 8'h00;
        portReceiveClockOut <= !portReceiveClockOut;
        portTransmitClockOut <= !portTransmitClockOut;
      end
      else
        divCount <= divCount + 8'h01;
    end
  end
  wire dceRise = divCount + 8'h01 >= halfPeriod && !portReceiveClockOut;
  wire rxTick = dceMode ? dceRise : (syncB[6] && !rxClkLast);
  wire txTick = dceMode ? dceRise : (syncB[5] && !txClkLast);

  // ----------------------------------------------------------------------------
  // receive framing, length and crc
  // ----------------------------------------------------------------------------
  eth_port_pkg::rx_state_t rxState;
  logic [7:0] shiftByte;
  logic [1:0] symCount;
  logic [10:0] byteCount;
  logic [31:0] crc;
  logic [15:0] typeField;
  logic [15:0] opField;
  logic sawEr;
  logic sawCol;
  logic frameEnd;

  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    return c;
  endfunction : crcByte

  wire [1:0] lastSym = rmiiMode ? 2'd3 : 2'd1; // four dibits or two nibbles a byte
  wire [7:0] nextByte = rmiiMode ? {rxdB[1:0], shiftByte[7:2]} : {rxdB, shiftByte[7:4]};
  wire sfdSeen = rmiiMode ? (rxdB[1:0] == 2'b11) : (rxdB == 4'hd);

  // the byte counter starts after the delimiter, so preamble never counts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxState <= eth_port_pkg::RX_IDLE;
      shiftByte <= 8'h00;
      symCount <= 2'd0;
      byteCount <= 11'h000;
      crc <= 32'hffffffff;
      typeField <= 16'h0;
      opField <= 16'h0;
      sawEr <= 1'b0;
      sawCol <= 1'b0;
      frameEnd <= 1'b0;
    end
    else
    begin
      frameEnd <= 1'b0;
      // a dropped data valid ends the frame even when the link clock has stopped
      if (rxTick || (rxState == eth_port_pkg::RX_DATA && !syncB[4]))
      begin
        case (rxState)
          eth_port_pkg::RX_IDLE:
            if (syncB[4] && macOn && !overflowLatch)
            begin
              rxState <= eth_port_pkg::RX_PRE;
              sawEr <= 1'b0;
              sawCol <= 1'b0;
            end
          eth_port_pkg::RX_PRE:
            if (!syncB[4])
              rxState <= eth_port_pkg::RX_IDLE;
            else if (sfdSeen)
            begin
              rxState <= eth_port_pkg::RX_DATA;
              symCount <= 2'd0;
              byteCount <= 11'h000;
              crc <= 32'hffffffff;
            end
          eth_port_pkg::RX_DATA:
            if (!syncB[4])
            begin
              rxState <= eth_port_pkg::RX_IDLE;
              frameEnd <= 1'b1;
            end
            else
            begin
              sawEr <= sawEr | syncB[3];
              sawCol <= sawCol | syncB[2];
              shiftByte <= nextByte;
              symCount <= (symCount == lastSym) ? 2'd0 : symCount + 2'd1;
              if (symCount == lastSym)
              begin
                crc <= crcByte(crc, nextByte);
                if (byteCount != 11'h7ff)
                  byteCount <= byteCount + 11'h001;
                if (byteCount == 11'd12 || byteCount == 11'd13)
                  typeField <= {typeField[7:0], nextByte};
                if (byteCount == 11'd14 || byteCount == 11'd15)
                  opField <= {opField[7:0], nextByte};
              end
            end
          default:
            rxState <= eth_port_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // error set of the closing frame: er, dribble, crc, length, control, unsupported
  wire isControl = typeField == `PAUSE_TYPE;
  wire [5:0] rxErr = {isControl && opField != `PAUSE_OPCODE, isControl && fullDuplex,
                      typeField <= 16'd1500 && typeField > byteCount - `HDR_BYTES,
                      crc != `CRC_RESIDUE, symCount != 2'd0, sawEr};
  wire [5:0] rejectMask = hostless_mode_pin ? 6'h3f : rxRejectCtrl;
  wire tooLong = byteCount > maxFrame; // byte compare equals the bit limit of size times 8
  wire runt = byteCount < `RUNT_BYTES;
  wire rejectNow = |(rxErr & rejectMask) || tooLong || runt || sawCol;

  // most recent frame overwrites the receive status and is judged once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxStatus <= 32'h0;
      rxFrameAccept <= 1'b0;
      rxFrameReject <= 1'b0;
      ppFrameReject <= 1'b0;
    end
    else
    begin
      rxFrameAccept <= frameEnd && !rejectNow;
      rxFrameReject <= frameEnd && rejectNow;
      ppFrameReject <= ppFrameDone && ppFrameLen > maxFrame;
      if (frameEnd)
        rxStatus <= {2'b00, isControl && opField != `PAUSE_OPCODE, isControl, 1'b0, tooLong, runt, sawCol,
                     2'b00, rxErr, 5'h00, byteCount};
    end
  end

  // ----------------------------------------------------------------------------
  // overflow, jam and pause
  // ----------------------------------------------------------------------------
  // the set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      overflowLatch <= 1'b0;
    else if (queueOverflow)
      overflowLatch <= 1'b1;
    else if (doWrite && wrAddr == `PORT_STATUS_OFS && wrStrb[0] && wrData[0])
      overflowLatch <= 1'b0;
  end

  eth_port_pkg::jam_state_t jamState;
  logic [4:0] jamCount;
  wire jamWanted = !fullDuplex && (autoFlow ? queueAboveHigh : globalControl[`GCR_JAM_ENABLE]);
  wire frameStart = rxTick && rxState == eth_port_pkg::RX_IDLE && syncB[4] && macOn;
  wire [4:0] jamSyms = rmiiMode ? 5'(`JAM_BYTES * 4) : 5'(`JAM_BYTES * 2);
  // decision taken only at a frame's first symbol, so a frame already running is spared
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jamState <= eth_port_pkg::JAM_OFF;
      jamCount <= 5'h00;
      txJamEn <= 1'b0;
      txd <= 4'h0;
    end
    else
    begin
      case (jamState)
        eth_port_pkg::JAM_OFF:
          if (frameStart && jamWanted) // every new frame while high
          begin
            jamState <= eth_port_pkg::JAM_ON;
            jamCount <= 5'h00;
          end
        eth_port_pkg::JAM_ON:
          if (txTick)
          begin
            txJamEn <= 1'b1; // looks like a plain collision to the sender
            txd <= 4'h5;
            jamCount <= jamCount + 5'h01;
            if (jamCount == jamSyms)
            begin
              jamState <= eth_port_pkg::JAM_OFF;
              txJamEn <= 1'b0;
              txd <= 4'h0;
            end
          end
        default:
          jamState <= eth_port_pkg::JAM_OFF;
      endcase
    end
  end

  assign pauseTaken = pauseReq && !autoFlow;
  // automatic pause is one request per frame seen while the queue is high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pauseSend <= 1'b0;
    else
      pauseSend <= (autoFlow && fullDuplex && frameEnd && queueAboveHigh) || pauseTaken;
  end

  // ----------------------------------------------------------------------------
  // transmit status, retry and flush
  // ----------------------------------------------------------------------------
  wire [9:0] retryMask = hostless_mode_pin ? 10'h3ff : {txRetryCtrl[`TRC_HEARTBEAT_RESEND], txRetryCtrl[`TRC_DEFER_RESEND],
                                             txRetryCtrl[7:0]};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txStatus <= 10'h000;
      txRetry <= 1'b0;
      txQueueFlush <= 1'b0;
    end
    else
    begin
      txRetry <= txFrameDone && |(txErrors & retryMask);
      txQueueFlush <= txFrameDone && txErrors[`TFS_NO_CARRIER] && txRetryCtrl[`TRC_NO_CARRIER_FLUSH];
      if (txFrameDone)
        txStatus <= txErrors;
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  sequence s_jamStart;
    frameStart && jamWanted && jamState == eth_port_pkg::JAM_OFF;
  endsequence
  a_jam_on_high: assert property (@(posedge clk) disable iff (!rst_n)
    s_jamStart |=> jamState == eth_port_pkg::JAM_ON) else $error("jam not started");
  a_jam_half_only: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(jamState == eth_port_pkg::JAM_ON) |-> !$past(fullDuplex)) else $error("jam in full duplex");
  a_jam_frame_start: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(jamState == eth_port_pkg::JAM_ON) |-> $past(frameStart)) else $error("jam outside frame start");
  a_overflow_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    overflowLatch && rxState == eth_port_pkg::RX_IDLE |=> rxState == eth_port_pkg::RX_IDLE)
    else $error("frame accepted after overflow");
  a_runt_rejected: assert property (@(posedge clk) disable iff (!rst_n)
    frameEnd && (runt || sawCol) |=> rxFrameReject && !rxFrameAccept) else $error("runt accepted");
  a_long_rejected: assert property (@(posedge clk) disable iff (!rst_n)
    ppFrameDone && ppFrameLen > maxFrame |=> ppFrameReject) else $error("long frame passed");
  a_flush_nocarrier: assert property (@(posedge clk) disable iff (!rst_n)
    txQueueFlush |-> $past(txErrors[`TFS_NO_CARRIER] && txFrameDone)) else $error("flush without cause");
  a_pause_auto: assert property (@(posedge clk) disable iff (!rst_n)
    autoFlow && fullDuplex && frameEnd && queueAboveHigh |=> pauseSend) else $error("pause missing");
  a_status_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(frameEnd) |-> $stable(rxStatus)) else $error("status changed without frame");
endmodule : ethernet_port_flow_and_frame_ctrl

// [tb/eth_phy_model.sv]
// behavioural phy that sends nibble frames on its own link clock
`timescale 1ns/10ps
module eth_phy_model (
  // link pins
  output logic linkClk,
  output logic rxDv,
  output logic [3:0] rxd
);
  initial {linkClk, rxDv, rxd} = '0;
  // preamble, start nibble, payload; clock stands still between frames
  task send(input int n);
    #20; // keep link edges off the bench clock edges
    for (int i = 0; i < 16 + 2 * n; i++)
    begin
      rxDv = 1'b1;
      rxd = (i < 15) ? 4'h5 : (i == 15) ? 4'hd : 4'(i * 3);
      #400 linkClk = 1'b1;
      #400 linkClk = 1'b0;
    end
    rxDv = 1'b0;
    rxd = ~rxd; // released data never repeats the last nibble
  endtask : send
endmodule : eth_phy_model

// [tb/ethernet_port_flow_and_frame_ctrl_tb.sv]
// self-checking bench of the ethernet port block
`timescale 1ns/10ps
module ethernet_port_flow_and_frame_ctrl_tb;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, ppFrameDone, txFrameDone, queueAboveHigh, sawJam;
  logic awready, wready, bvalid, arready, rvalid, txJamEn, ppFrameReject, rxFrameAccept, rxFrameReject;
  logic txRetry, txQueueFlush, pauseSend, linkClk, rxDv;
  logic [3:0] rxd;
  logic [7:0] awaddr, araddr, lfsr;
  logic [31:0] wdata, rdata;
  logic [10:0] ppFrameLen;
  logic [9:0] txErrors;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb, txd;
  logic rxEr, col, queueOverflow, portReceiveClockOut, portTransmitClockOut, portClockOe;
  logic [33:0] expQ[$];
  int num_errors, samples_checked;
  eth_phy_model i_eth_phy_model (.linkClk, .rxDv, .rxd);
  ethernet_port_flow_and_frame_ctrl i_ethernet_port_flow_and_frame_ctrl (.clk, .rst_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .hostlessModePin(1'b0), .autoFlowPin(1'b0), .duplexSelectPin(1'b0),
    .interfaceWidthSelectPin(1'b0), .portRoleSelectPin(1'b0), .portReceiveClock(linkClk), .portTransmitClock(linkClk),
    .rxDv, .rxEr, .rxd, .col, .portReceiveClockOut, .portTransmitClockOut, .portClockOe, .txJamEn,
    .txd, .queueAboveHigh, .queueOverflow, .ppFrameDone, .ppFrameLen, .ppFrameReject, .rxFrameAccept,
    .rxFrameReject, .txFrameDone, .txErrors, .txRetry, .txQueueFlush, .pauseSend);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // watchdog, well past the longest frame
  initial
  begin
    #600000;
    num_errors++;
    print_verdict();
  end
  function automatic logic [7:0] nextRand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nextRand
  function automatic logic [33:0] nextExp();
    return expQ.size() ? expQ.pop_front() : 'x;
  endfunction : nextExp
  task check(input logic [33:0] seen, input logic [33:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // pulses are checked before bus answers that land on the same edge
  always @(posedge clk)
  begin
    if (|{ppFrameReject, txQueueFlush, txRetry, pauseSend, rxFrameReject, rxFrameAccept})
      check({2'b11, 26'h0, ppFrameReject, txQueueFlush, txRetry, pauseSend, rxFrameReject, rxFrameAccept}, nextExp());
    if (rvalid && rready)
      check({rresp, rdata}, nextExp());
    else if (bvalid && bready)
      check({bresp, 32'h0}, nextExp());
    if (txJamEn && txd == 4'h5) // jam pattern on the line
      sawJam <= 1'b1;
  end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw;
    expQ.push_back({r, 32'h0});
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(posedge clk);
      pa = pa && !awready;
      pw = pw && !wready;
      awvalid <= pa;
      wvalid <= pw;
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [33:0] e);
    expQ.push_back(e);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
  endtask : rd
  task ev(input logic isTx, input logic [10:0] v);
    @(posedge clk);
    {txFrameDone, ppFrameDone, txErrors, ppFrameLen} <= {isTx, !isTx, v[9:0], v};
    @(posedge clk);
    {txFrameDone, ppFrameDone} <= 2'b00;
    repeat (4) @(posedge clk);
  endtask : ev
  task print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, ppFrameDone, txFrameDone, queueAboveHigh, sawJam} = '0;
    {awaddr, araddr, wdata, ppFrameLen, txErrors} = '0;
    {wstrb, rxEr, col, queueOverflow} = 7'h78;
    lfsr = 8'h4e;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h0c, 34'h7);
    rd(8'h10, 34'he0);
    rd(8'h18, 34'h3f);
    rd(8'h2c, 34'h200000000);
    wr(8'h30, 32'h1, 2'b10);
    wr(8'h00, 32'h3, 2'b00);
    $display("registers done");
    queueAboveHigh <= 1'b1;
    expQ.push_back(34'h300000002);
    i_eth_phy_model.send(20);
    repeat (20) @(posedge clk);
    check({33'h0, sawJam}, 34'h1);
    queueAboveHigh <= 1'b0;
    wr(8'h0c, 32'h0, 2'b00);
    wr(8'h10, 32'h80, 2'b00);
    lfsr = nextRand(lfsr);
    expQ.push_back(34'h300000020);
    ev(1'b0, 11'h81 + 11'(lfsr[3:0]));
    ev(1'b0, 11'h80);
    wr(8'h14, 32'h400, 2'b00);
    expQ.push_back(34'h300000010);
    ev(1'b1, 11'h002);
    wr(8'h14, 32'h002, 2'b00);
    expQ.push_back(34'h300000008);
    ev(1'b1, 11'h002);
    wr(8'h04, 32'h0, 2'b00);
    wr(8'h08, 32'h1, 2'b00);
    expQ.push_back(34'h300000004);
    queueOverflow <= 1'b1;
    @(posedge clk) queueOverflow <= 1'b0;
    i_eth_phy_model.send(64);
    rd(8'h28, 34'h1);
    wr(8'h28, 32'h1, 2'b00);
    wr(8'h18, 32'h0, 2'b00);
    wr(8'h00, 32'h7, 2'b00);
    wr(8'h04, 32'h1, 2'b00);
    queueAboveHigh <= 1'b1;
    expQ.push_back(34'h300000005);
    i_eth_phy_model.send(64);
    repeat (10) @(posedge clk);
    check({33'h0, portClockOe}, 34'h0);
    $display("frames done");
    check({2'b0, 32'(expQ.size())}, 34'h0);
    print_verdict();
  end
endmodule : ethernet_port_flow_and_frame_ctrl_tb
